/* rtl/psr_pkg.sv */
package psr_pkg;

    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned CONV_PERIOD_NS = 500000;
    localparam int unsigned MAINT_EXTRA_NS = 400000;
    localparam int unsigned CONV_CYCLES = CONV_PERIOD_NS / CLK_PERIOD_NS;
    localparam int unsigned MAINT_CYCLES = MAINT_EXTRA_NS / CLK_PERIOD_NS;
    localparam int CONV_CNT_W = 17;
    localparam logic [7:0] MAINT_IDX = 8'hfe;
    localparam logic [7:0] CYC_IDX_ONE = 8'h01;

    localparam logic [6:0] DEV_ADDR_DEF = 7'h28;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] BITS_ONE = 4'h1;
    localparam logic [2:0] BYTES_MAX = 3'h4;
    localparam logic [2:0] BYTES_ONE = 3'h1;
    localparam logic [5:0] SPI_FETCH_BITS = 6'h08;
    localparam logic [5:0] SPI_BITS_ONE = 6'h01;
    localparam logic [1:0] BUF_DEPTH = 2'h2;
    localparam logic [1:0] BUF_ONE = 2'h1;

    typedef enum logic [1:0] {
        PSR_ST_NEW = 2'b00,
        PSR_ST_STALE = 2'b10,
        PSR_ST_ERR = 2'b11
    } psr_stat_t;

    typedef struct packed {
        logic [13:0] pres;
        logic [10:0] temp;
    } psr_meas_t;

    typedef struct packed {
        psr_stat_t stat;
        psr_meas_t meas;
        logic [4:0] pad;
    } psr_frame_t;

    typedef enum logic [2:0] {
        I2C_IDLE = 3'b000,
        I2C_ADDR = 3'b001,
        I2C_AACK = 3'b010,
        I2C_TX = 3'b011,
        I2C_TACK = 3'b100,
        I2C_SKIP = 3'b101
    } psr_i2c_st_t;

endpackage : psr_pkg

/* rtl/psr_readout.sv */
`timescale 1ns/10ps

module psr_sync #(
    parameter int W = 1
) (
    input wire logic clk, // Sampling clock
    input wire logic nrst, // Async reset, active low
    input wire logic [W-1:0] d, // Asynchronous inputs
    output logic [W-1:0] q // Synchronised outputs
);
    logic [W-1:0] s1_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1_q <= '1;
            q <= '1;
        end else begin
            s1_q <= d;
            q <= s1_q;
        end
    end
endmodule : psr_sync

module psr_readout #(
    parameter int unsigned CONV_P = psr_pkg::CONV_CYCLES,
    parameter int unsigned MAINT_P = psr_pkg::MAINT_CYCLES,
    parameter logic [6:0] DEV_ADDR = psr_pkg::DEV_ADDR_DEF
) (
    input wire logic I_MCLK, // Block clock, 125 MHz
    input wire logic I_NRST, // Async reset, active low
    input wire logic I_MEAS_VALID, // Converter offers a sample
    input wire psr_pkg::psr_meas_t I_MEAS, // Converter sample
    output logic O_MEAS_READY, // Buffer can take a sample
    output logic O_DRDY, // Fresh result waiting
    input wire logic I_SCL, // Two-wire clock pin
    input wire logic I_SDA, // Two-wire data pin level
    output logic O_SDA, // Two-wire data out, always low
    output logic O_SDA_OE, // Pull data low when high
    input wire logic I_SCLK, // Serial peripheral clock
    input wire logic I_SS_N, // Slave select, active low
    output logic O_MISO, // Serial peripheral data out
    output logic O_MISO_OE // MISO driven when high
);
    ////////////////////////////////////////////////////////////////////////////
    logic [3:0] syn;
    logic s_scl, s_sda, s_sclk, s_sclk_n, s_ss_n;
    logic scl_p_q, sda_p_q, sclk_p_q, ss_p_q;

    psr_sync #(.W(4)) u_sync (
        .clk(I_MCLK),
        .nrst(I_NRST),
        .d({I_SCL, I_SDA, ~I_SCLK, I_SS_N}),
        .q(syn)
    );
    // Serial clock kept inverted so the all-ones reset matches its idle low level
    assign {s_scl, s_sda, s_sclk_n, s_ss_n} = syn;
    assign s_sclk = ~s_sclk_n;

    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            sclk_p_q <= 1'b0;
            ss_p_q <= 1'b1;
        end else begin
            scl_p_q <= s_scl;
            sda_p_q <= s_sda;
            sclk_p_q <= s_sclk;
            ss_p_q <= s_ss_n;
        end
    end

    logic scl_rise, scl_fall, start_ev, stop_ev, sclk_rise, sclk_fall, ss_fall;
    assign scl_rise = s_scl & ~scl_p_q;
    assign scl_fall = ~s_scl & scl_p_q;
    assign start_ev = s_scl & scl_p_q & sda_p_q & ~s_sda;
    assign stop_ev = s_scl & scl_p_q & ~sda_p_q & s_sda;
    assign sclk_rise = s_sclk & ~sclk_p_q;
    assign sclk_fall = ~s_sclk & sclk_p_q;
    assign ss_fall = ~s_ss_n & ss_p_q;

    ////////////////////////////////////////////////////////////////////////////
    // Two-entry buffer: a sample waits here until the conversion cycle ends
    psr_pkg::psr_meas_t buf_q [2];
    logic wr_ptr_q, rd_ptr_q;
    logic [1:0] buf_cnt_q, buf_cnt_d;
    logic push, pop, conv_end;

    assign push = I_MEAS_VALID & O_MEAS_READY;
    assign pop = conv_end & (buf_cnt_q != 2'h0);

    always_comb begin
        buf_cnt_d = buf_cnt_q;
        if (push && !pop) begin
            buf_cnt_d = buf_cnt_q + BUF_ONE_W();
        end else if (pop && !push) begin
            buf_cnt_d = buf_cnt_q - BUF_ONE_W();
        end
    end

    function automatic logic [1:0] BUF_ONE_W();
        return psr_pkg::BUF_ONE;
    endfunction : BUF_ONE_W

    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            buf_cnt_q <= 2'h0;
            O_MEAS_READY <= 1'b1;
            buf_q[0] <= '0;
            buf_q[1] <= '0;
        end else begin
            if (push) begin
                buf_q[wr_ptr_q] <= I_MEAS;
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            buf_cnt_q <= buf_cnt_d;
            O_MEAS_READY <= (buf_cnt_d != psr_pkg::BUF_DEPTH);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Free-running conversion cycle, blind to bus activity
    logic [psr_pkg::CONV_CNT_W-1:0] conv_cnt_q, conv_lim;
    logic [7:0] cyc_idx_q;
    logic maint;
    psr_pkg::psr_frame_t frame_q;
    logic fetch_i2c_q, fetch_spi_q;

    assign maint = (cyc_idx_q == psr_pkg::MAINT_IDX);
    assign conv_lim = maint ? psr_pkg::CONV_CNT_W'(CONV_P + MAINT_P - 1)
                            : psr_pkg::CONV_CNT_W'(CONV_P - 1);
    assign conv_end = (conv_cnt_q == conv_lim);

    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            conv_cnt_q <= '0;
            cyc_idx_q <= 8'h00;
        end else if (conv_end) begin
            conv_cnt_q <= '0;
            cyc_idx_q <= maint ? 8'h00 : cyc_idx_q + psr_pkg::CYC_IDX_ONE;
        end else begin
            conv_cnt_q <= conv_cnt_q + psr_pkg::CONV_CNT_W'(1);
        end
    end

    // An update wins over a fetch in the same cycle, so that fetch never marks the fresh data stale
    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            frame_q <= '{stat: psr_pkg::PSR_ST_ERR, meas: '0, pad: '0};
            O_DRDY <= 1'b0;
        end else if (conv_end) begin
            O_DRDY <= 1'b1;
            if (pop) begin
                frame_q.stat <= psr_pkg::PSR_ST_NEW;
                frame_q.meas <= buf_q[rd_ptr_q];
            end else begin
                frame_q.stat <= psr_pkg::PSR_ST_ERR;
            end
        end else if (fetch_i2c_q || fetch_spi_q) begin
            O_DRDY <= 1'b0;
            if (frame_q.stat == psr_pkg::PSR_ST_NEW) begin
                frame_q.stat <= psr_pkg::PSR_ST_STALE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Two-wire slave
    psr_pkg::psr_i2c_st_t st_q;
    logic [7:0] addr_sh_q;
    logic [31:0] tx_sh_q;
    logic [3:0] bits_q;
    logic [2:0] nbytes_q;
    logic err_q, saw_clk_q, rw_q, ack_q;

    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            st_q <= psr_pkg::I2C_IDLE;
            addr_sh_q <= 8'h00;
            tx_sh_q <= 32'h0000_0000;
            bits_q <= 4'h0;
            nbytes_q <= 3'h0;
            err_q <= 1'b0;
            saw_clk_q <= 1'b0;
            rw_q <= 1'b0;
            ack_q <= 1'b0;
            O_SDA_OE <= 1'b0;
            O_SDA <= 1'b0;
            fetch_i2c_q <= 1'b0;
        end else begin
            fetch_i2c_q <= 1'b0;
            if (start_ev) begin
                saw_clk_q <= 1'b0;
                bits_q <= 4'h0;
                O_SDA_OE <= 1'b0;
                if (st_q == psr_pkg::I2C_TX || st_q == psr_pkg::I2C_TACK) begin
                    err_q <= 1'b1;
                    st_q <= psr_pkg::I2C_SKIP;
                end else if (err_q) begin
                    err_q <= 1'b0;
                    st_q <= psr_pkg::I2C_SKIP;
                end else begin
                    st_q <= psr_pkg::I2C_ADDR;
                end
            end else if (stop_ev) begin
                if (st_q == psr_pkg::I2C_ADDR && !saw_clk_q) begin
                    err_q <= 1'b1;
                end
                st_q <= psr_pkg::I2C_IDLE;
                O_SDA_OE <= 1'b0;
            end else begin
                if (scl_rise || scl_fall) begin
                    saw_clk_q <= 1'b1;
                end
                case (st_q)
                    psr_pkg::I2C_ADDR: begin
                        // Sampled on rising clock only; a glitch before it is the master's fault
                        if (scl_rise) begin
                            addr_sh_q <= {addr_sh_q[6:0], s_sda};
                            bits_q <= bits_q + psr_pkg::BITS_ONE;
                        end else if (scl_fall && bits_q == psr_pkg::BYTE_BITS) begin
                            if (addr_sh_q[7:1] == DEV_ADDR) begin
                                rw_q <= addr_sh_q[0];
                                O_SDA_OE <= 1'b1;
                                st_q <= psr_pkg::I2C_AACK;
                            end else begin
                                st_q <= psr_pkg::I2C_SKIP;
                            end
                        end
                    end
                    psr_pkg::I2C_AACK: begin
                        if (scl_fall) begin
                            bits_q <= 4'h0;
                            nbytes_q <= 3'h0;
                            if (rw_q) begin
                                O_SDA_OE <= ~frame_q[31];
                                tx_sh_q <= {frame_q[30:0], 1'b0};
                                st_q <= psr_pkg::I2C_TX;
                            end else begin
                                // Writes carry nothing for this device
                                O_SDA_OE <= 1'b0;
                                st_q <= psr_pkg::I2C_SKIP;
                            end
                        end
                    end
                    psr_pkg::I2C_TX: begin
                        if (scl_rise) begin
                            bits_q <= bits_q + psr_pkg::BITS_ONE;
                        end else if (scl_fall) begin
                            if (bits_q == psr_pkg::BYTE_BITS) begin
                                O_SDA_OE <= 1'b0;
                                st_q <= psr_pkg::I2C_TACK;
                            end else begin
                                O_SDA_OE <= ~tx_sh_q[31];
                                tx_sh_q <= {tx_sh_q[30:0], 1'b0};
                            end
                        end
                    end
                    psr_pkg::I2C_TACK: begin
                        if (scl_rise) begin
                            ack_q <= ~s_sda;
                            nbytes_q <= nbytes_q + psr_pkg::BYTES_ONE;
                            fetch_i2c_q <= (nbytes_q == 3'h0);
                        end else if (scl_fall) begin
                            if (ack_q && nbytes_q != psr_pkg::BYTES_MAX) begin
                                bits_q <= 4'h0;
                                O_SDA_OE <= ~tx_sh_q[31];
                                tx_sh_q <= {tx_sh_q[30:0], 1'b0};
                                st_q <= psr_pkg::I2C_TX;
                            end else begin
                                O_SDA_OE <= 1'b0;
                                st_q <= psr_pkg::I2C_SKIP;
                            end
                        end
                    end
                    psr_pkg::I2C_IDLE, psr_pkg::I2C_SKIP: begin
                        O_SDA_OE <= 1'b0;
                    end
                    default: begin
                        st_q <= psr_pkg::I2C_IDLE;
                        O_SDA_OE <= 1'b0;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial peripheral slave, read only, mode 0
    logic [31:0] spi_sh_q;
    logic [5:0] spi_bits_q;

    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            spi_sh_q <= 32'h0000_0000;
            spi_bits_q <= 6'h00;
            O_MISO <= 1'b0;
            O_MISO_OE <= 1'b0;
            fetch_spi_q <= 1'b0;
        end else begin
            fetch_spi_q <= 1'b0;
            if (s_ss_n) begin
                O_MISO_OE <= 1'b0;
            end else if (ss_fall) begin
                O_MISO_OE <= 1'b1;
                O_MISO <= frame_q[31];
                spi_sh_q <= {frame_q[30:0], 1'b0};
                spi_bits_q <= 6'h00;
            end else if (sclk_rise) begin
                spi_bits_q <= spi_bits_q + psr_pkg::SPI_BITS_ONE;
                fetch_spi_q <= (spi_bits_q + psr_pkg::SPI_BITS_ONE == psr_pkg::SPI_FETCH_BITS);
            end else if (sclk_fall) begin
                O_MISO <= spi_sh_q[31];
                spi_sh_q <= {spi_sh_q[30:0], 1'b0};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_NRST);

    AST_DRDY_ON_UPDATE: assert property (conv_end |=> O_DRDY)
        else $error("data-ready not raised after update");
    AST_MAINT_LEN: assert property ((maint &&
        conv_cnt_q == psr_pkg::CONV_CNT_W'(CONV_P - 1)) |-> !conv_end)
        else $error("maintenance cycle ended at normal length");
    AST_IDLE_RELEASED: assert property ((st_q == psr_pkg::I2C_IDLE) |=>
        (!O_SDA_OE || st_q != psr_pkg::I2C_IDLE))
        else $error("data line driven while bus idle");
    AST_ADDR_ACK: assert property ((st_q == psr_pkg::I2C_ADDR && scl_fall && !start_ev &&
        !stop_ev && bits_q == psr_pkg::BYTE_BITS && addr_sh_q[7:1] == DEV_ADDR) |=>
        (O_SDA_OE && st_q == psr_pkg::I2C_AACK))
        else $error("matching address not acknowledged");
    AST_CHANGE_LOW: assert property (($changed(O_SDA_OE) && !$past(start_ev) &&
        !$past(stop_ev)) |-> !scl_p_q)
        else $error("data changed while clock high");
    AST_NACK_RELEASE: assert property ((st_q == psr_pkg::I2C_TACK && scl_fall && !ack_q &&
        !start_ev && !stop_ev) |=> (!O_SDA_OE && st_q == psr_pkg::I2C_SKIP))
        else $error("bus not released after not-acknowledge");
    AST_MAX_BYTES: assert property ((st_q == psr_pkg::I2C_TX) |->
        nbytes_q < psr_pkg::BYTES_MAX)
        else $error("more than four bytes sent");
    AST_STARTSTOP_ERR: assert property ((stop_ev && st_q == psr_pkg::I2C_ADDR &&
        !saw_clk_q) |=> err_q ##0 (st_q == psr_pkg::I2C_IDLE))
        else $error("start-stop error not flagged");
    AST_RESTART_STALL: assert property ((start_ev && (st_q == psr_pkg::I2C_TX ||
        st_q == psr_pkg::I2C_TACK)) |=>
        (err_q && st_q == psr_pkg::I2C_SKIP && !O_SDA_OE))
        else $error("repeated start did not stall");
    AST_SS_STOP: assert property ((s_ss_n && !ss_p_q) |=> (!O_MISO_OE) [*2])
        else $error("data out still driven after deselect");

    COV_MAINT: cover property (conv_end && maint);
    COV_I2C_FOUR: cover property (st_q == psr_pkg::I2C_TACK && scl_fall &&
        nbytes_q == psr_pkg::BYTES_MAX);
    COV_SPI_FETCH: cover property (fetch_spi_q);
    COV_BUF_FULL: cover property (buf_cnt_q == psr_pkg::BUF_DEPTH && !O_MEAS_READY);

endmodule : psr_readout

/* testbench/psr_host_model.sv */
`timescale 1ns/10ps

module psr_host_model (
    input wire logic i_sda, // Resolved two-wire data
    input wire logic i_miso, // Serial peripheral data
    output logic o_scl, // Two-wire clock
    output logic o_sda, // Data drive, 1 releases
    output logic o_sclk, // Serial clock, idle low
    output logic o_ss_n // Slave select
);
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
        o_sclk = 1'b0;
        o_ss_n = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Data moves mid-low so it never changes while the clock is high
    task automatic bit_io(input logic b, output logic r);
        #40 o_sda = b;
        #40 o_scl = 1'b1;
        #80 r = i_sda;
        o_scl = 1'b0;
    endtask : bit_io

    task automatic start;
        #40 o_sda = 1'b1;
        #40 o_scl = 1'b1;
        #80 o_sda = 1'b0;
        #80 o_scl = 1'b0;
    endtask : start

    task automatic stop;
        #40 o_sda = 1'b0;
        #40 o_scl = 1'b1;
        #80 o_sda = 1'b1;
        #80;
    endtask : stop

    // START then STOP with the clock left high throughout
    task automatic glitch;
        #80 o_sda = 1'b0;
        #160 o_sda = 1'b1;
        #160;
    endtask : glitch

    task automatic i2c_read(input logic [6:0] addr, input int n, input bit rs,
                            output logic [31:0] d, output logic ak);
        logic [7:0] a;
        logic r;
        a = {addr, 1'b1};
        d = 32'h0;
        start();
        for (int i = 7; i >= 0; i--) begin
            bit_io(a[i], r);
        end
        bit_io(1'b1, ak);
        if (ak === 1'b0) begin
            for (int k = 0; k < n; k++) begin
                for (int i = 0; i < 8; i++) begin
                    bit_io(1'b1, r);
                    d[31 - 8 * k - i] = r;
                end
                if (rs && k == 0) begin
                    start();
                    k = n;
                end else begin
                    bit_io(k == n - 1, r);
                end
            end
        end
        stop();
    endtask : i2c_read

    // Address byte only, then STOP; serves writes and foreign addresses
    task automatic i2c_addr(input logic [7:0] a, output logic ak);
        logic r;
        start();
        for (int i = 7; i >= 0; i--) begin
            bit_io(a[i], r);
        end
        bit_io(1'b1, ak);
        stop();
    endtask : i2c_addr

    // Sampled late in the high phase, well clear of the next change
    task automatic spi_read(input int n, output logic [31:0] d);
        d = 32'h0;
        #3 o_ss_n = 1'b0;
        #100;
        for (int i = 31; i >= 32 - 8 * n; i--) begin
            o_sclk = 1'b1;
            #28 d[i] = i_miso;
            #4 o_sclk = 1'b0;
            #32;
        end
        o_ss_n = 1'b1;
        #100;
    endtask : spi_read

endmodule : psr_host_model

/* testbench/testbench.sv */
`timescale 1ns/10ps

module testbench;
    localparam int C2 = 8;
    localparam int M2 = 20;
    logic clk, nrst, valid, ready, drdy, sda_o, sda_oe, sda2_oe, miso, miso_oe, ready2;
    logic scl, sda_h, sclk, ss_n;
    psr_pkg::psr_meas_t meas, ma, mb;
    int failures = 0;
    int checked = 0;
    wire logic sda_w = sda_h & ~(sda_oe & ~sda_o) & ~sda2_oe;
    // Undriven data shows the inverse of its last value
    wire logic miso_w = miso_oe ? miso : ~miso;

    psr_readout #(.CONV_P(3000), .MAINT_P(100)) psr_readout_inst (
        .I_MCLK(clk), .I_NRST(nrst), .I_MEAS_VALID(valid), .I_MEAS(meas),
        .O_MEAS_READY(ready), .O_DRDY(drdy), .I_SCL(scl), .I_SDA(sda_w), .O_SDA(sda_o),
        .O_SDA_OE(sda_oe), .I_SCLK(sclk), .I_SS_N(ss_n), .O_MISO(miso), .O_MISO_OE(miso_oe));

    // Short cycles so a full maintenance period fits; other address keeps it off the bus
    psr_readout #(.CONV_P(C2), .MAINT_P(M2), .DEV_ADDR(7'h29)) psr_readout_inst2 (
        .I_MCLK(clk), .I_NRST(nrst), .I_MEAS_VALID(1'b1), .I_MEAS(meas),
        .O_MEAS_READY(ready2), .O_DRDY(), .I_SCL(scl), .I_SDA(sda_w), .O_SDA(),
        .O_SDA_OE(sda2_oe), .I_SCLK(sclk), .I_SS_N(ss_n), .O_MISO(), .O_MISO_OE());

    psr_host_model psr_host_model_inst (.i_sda(sda_w), .i_miso(miso_w), .o_scl(scl),
        .o_sda(sda_h), .o_sclk(sclk), .o_ss_n(ss_n));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] frame(input psr_pkg::psr_stat_t s,
                                          input psr_pkg::psr_meas_t m, input int n);
        return {s, m, 5'h00} & ~(32'hffffffff >> (8 * n));
    endfunction : frame

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict;
        $display("comparisons %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict

    task automatic wait_drdy;
        int i;
        for (i = 0; i < 3500 && drdy !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (i == 3500) begin
            failures++;
            print_verdict();
        end
    endtask : wait_drdy

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_first;
        @(posedge clk);
        valid <= 1'b1;
        meas <= ma;
        @(posedge clk);
        meas <= mb;
        @(posedge clk);
        valid <= 1'b0;
        @(posedge clk);
        #1 check({ready, drdy}, 32'h0);
        wait_drdy();
        repeat (3) @(posedge clk);
        #1 check(ready, 1'b1);
        $display("first measurement done");
    endtask : t_first

    task automatic t_i2c;
        logic [31:0] d;
        logic ak;
        psr_host_model_inst.i2c_read(7'h28, 4, 1'b0, d, ak);
        check(ak, 1'b0);
        check(d, frame(psr_pkg::PSR_ST_NEW, ma, 4));
        check({drdy, sda_oe}, 32'h0);
        psr_host_model_inst.i2c_read(7'h28, 2, 1'b0, d, ak);
        check(d, frame(psr_pkg::PSR_ST_STALE, ma, 2));
        $display("two-wire read done");
    endtask : t_i2c

    task automatic t_spi;
        logic [31:0] d;
        wait_drdy();
        psr_host_model_inst.spi_read(3, d);
        check(d, frame(psr_pkg::PSR_ST_NEW, mb, 3));
        repeat (6) @(posedge clk);
        #1 check({miso_oe, drdy}, 32'h0);
        wait_drdy();
        psr_host_model_inst.spi_read(2, d);
        check(d[31:30], psr_pkg::PSR_ST_ERR);
        $display("serial peripheral read done");
    endtask : t_spi

    task automatic t_errors;
        logic [31:0] d;
        logic ak;
        for (int e = 0; e < 2; e++) begin
            if (e == 0) begin
                psr_host_model_inst.glitch();
            end else begin
                psr_host_model_inst.i2c_read(7'h28, 1, 1'b1, d, ak);
                check(ak, 1'b0);
            end
            psr_host_model_inst.i2c_read(7'h28, 1, 1'b0, d, ak);
            check(ak, 1'b1);
            psr_host_model_inst.i2c_read(7'h28, 1, 1'b0, d, ak);
            check(ak, 1'b0);
        end
        psr_host_model_inst.i2c_addr({7'h28, 1'b0}, ak);
        check({ak, sda_oe}, 32'h0);
        psr_host_model_inst.i2c_addr({7'h2a, 1'b1}, ak);
        check(ak, 1'b1);
        $display("bus error recovery done");
    endtask : t_errors

    // Each pop reopens the buffer, so ready rises mark the cycle ends
    task automatic t_maint;
        int last, t1, lng;
        logic prev;
        last = -1;
        t1 = -1;
        lng = 0;
        prev = ready2;
        for (int c = 0; c < 4300; c++) begin
            @(posedge clk);
            #1;
            if (ready2 === 1'b1 && prev !== 1'b1) begin
                if (last >= 0 && c - last == C2 + M2) begin
                    if (t1 >= 0) check(c - t1, 255 * C2 + M2);
                    t1 = c;
                    lng++;
                end else if (last >= 0) begin
                    check(c - last, C2);
                end
                last = c;
            end
            prev = ready2;
        end
        check(lng >= 2, 1'b1);
        $display("maintenance cycle done");
    endtask : t_maint

    initial begin
        nrst = 1'b0;
        valid = 1'b0;
        meas = '0;
        ma = '{pres: 14'h2abc, temp: 11'h5a3};
        mb = '{pres: 14'h1234, temp: 11'h2cd};
        @(posedge clk);
        #1 check({ready, drdy, sda_oe, miso_oe, sda_o}, 32'h10);
        @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        t_first();
        t_i2c();
        t_spi();
        t_errors();
        t_maint();
        print_verdict();
    end

endmodule : testbench
